// ===== src/sdram_decode_pkg.sv
// constants, register layout and carrier types for the sdram block decoder
package sdram_decode_pkg;

    // register byte offsets
    localparam logic [7:0]  OFS_MASK0     = 8'h00;
    localparam logic [7:0]  OFS_MASK1     = 8'h04;
    localparam logic [7:0]  OFS_CFG0      = 8'h08;
    localparam logic [7:0]  OFS_CFG1      = 8'h0c;
    localparam logic [7:0]  OFS_STATUS    = 8'h10;
    localparam logic [7:0]  OFS_IRQMASK   = 8'h14;
    localparam logic [7:0]  OFS_STATE     = 8'h18;

    // mask register fields
    localparam int          ENABLE_BIT    = 0;
    localparam int          ATM_LSB       = 1;
    localparam int          ATM_MSB       = 6;
    localparam int          WLOCK_BIT     = 8;
    localparam logic [31:0] BASE_FIELD    = 32'hfffc0000;
    localparam logic [31:0] MASK_WMASK    = 32'hfffc017f;
    localparam logic [31:0] MASK_RESET    = 32'h00000000;

    // block configuration fields
    localparam int          XCOL_BIT      = 1;
    localparam int          PAGE_BIT      = 2;
    localparam int          PW_LSB        = 4;
    localparam int          PW_MSB        = 5;
    localparam logic [31:0] CFG_WMASK     = 32'hfffc0036;
    localparam logic [31:0] CFG_RESET     = 32'h00000000;

    // port width codes
    localparam logic [1:0]  PW_32         = 2'b00;
    localparam logic [1:0]  PW_8          = 2'b01;

    // access class one-hot positions inside the access-type mask
    localparam int          CLS_UD        = 0;
    localparam int          CLS_UC        = 1;
    localparam int          CLS_SD        = 2;
    localparam int          CLS_SC        = 3;
    localparam int          CLS_ALT       = 4;
    localparam int          CLS_CPU       = 5;

    // status bits
    localparam int          ST_WLOCK0     = 0;
    localparam int          ST_WLOCK1     = 1;
    localparam int          ST_MISS       = 2;
    localparam int          ST_W          = 3;
    localparam logic [2:0]  STATUS_RESET  = 3'h0;

    // row address starts at this bit
    localparam int          ROW_LSB       = 9;

    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic        alt_master;
        logic        cpu_space;
        logic        supervisor;
        logic        code;
    } acc_req_t;

    typedef struct packed {
        logic [1:0]  cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [31:0] addr;
    } sdram_pins_t;

    localparam sdram_pins_t PINS_IDLE = '{cs_n: 2'b11, ras_n: 1'b1,
                                          cas_n: 1'b1, we_n: 1'b1,
                                          addr: 32'h00000000};

endpackage : sdram_decode_pkg

// ===== src/sdram_block_decode.sv
// sdram block decode, access-type filtering and row/column address mux
`timescale 1ns/10ps
module sdram_block_decode (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          acc_valid,
    input  wire sdram_decode_pkg::acc_req_t    acc_req,
    output logic                               acc_ready,
    output logic                               acc_done,
    output logic      [1:0]                    acc_hit,
    output logic                               wlock_err,
    output logic                               cs_pass,
    output sdram_decode_pkg::sdram_pins_t      sdram,
    output logic                               irq
);
    import sdram_decode_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_ACT, S_RDWR, S_PRE} state_t;

    state_t            state_ff, nxt_state;
    logic [31:0]       mask_ff [2];
    logic [31:0]       cfg_ff  [2];
    logic [ST_W-1:0]   status_ff, nxt_status;
    logic [ST_W-1:0]   irqmask_ff;
    logic [31:0]       prdata_ff;
    acc_req_t          cur_ff, nxt_cur;
    logic              blk_ff, nxt_blk;
    logic              pend_ff, nxt_pend;
    logic              open_ff, nxt_open;
    logic              open_blk_ff, nxt_open_blk;
    logic [22:0]       open_row_ff, nxt_open_row;
    sdram_pins_t       sdram_ff, nxt_sdram;
    logic              done_ff, hit0_ff, hit1_ff, wl_ff, csp_ff;

    // class of the incoming access
    logic [5:0] cls;
    always_comb begin
        cls = 6'h00;
        if (acc_req.alt_master) begin
            cls[CLS_ALT] = 1'b1;
        end else if (acc_req.cpu_space) begin
            cls[CLS_CPU] = 1'b1;
        end else if (acc_req.supervisor) begin
            cls[acc_req.code ? CLS_SC : CLS_SD] = 1'b1;
        end else begin
            cls[acc_req.code ? CLS_UC : CLS_UD] = 1'b1;
        end
    end

    function automatic logic blk_hit(input logic [31:0] msk,
                                     input logic [31:0] cfg,
                                     input logic [31:0] a,
                                     input logic [5:0]  c);
        logic en, base_ok, cls_ok;
        begin
            en      = msk[ENABLE_BIT];
            base_ok = (((a ^ cfg) & ~msk & BASE_FIELD) == 32'h0);
            cls_ok  = ((msk[ATM_MSB:ATM_LSB] & c) == 6'h00);
            return en && base_ok && cls_ok;
        end
    endfunction : blk_hit

    // row or column image of an address on the multiplexed pins
    function automatic logic [31:0] mux_addr(input logic [31:0] a,
                                             input logic [1:0]  pw,
                                             input logic        xcol,
                                             input logic        col);
        logic [31:0] r;
        int          sh;
        begin
            r  = 32'h0;
            sh = (pw == PW_8) ? 0 : ((pw == PW_32) ? 2 : 1);
            if (!col) begin
                r[31:ROW_LSB] = a[31:ROW_LSB];
            end else begin
                for (int i = 0; i <= 8; i++) begin
                    if (i >= sh) begin
                        r[17-i] = a[i];
                    end
                end
                if (xcol) begin
                    if (pw == PW_8) begin
                        r[19] = a[18];
                    end else if (pw == PW_32) begin
                        r[17] = a[16];
                    end else begin
                        r[18] = a[17];
                    end
                end
            end
            return r;
        end
    endfunction : mux_addr

    // decode of the incoming access
    wire   take     = acc_valid && acc_ready;
    wire   hit0     = blk_hit(mask_ff[0], cfg_ff[0], acc_req.addr, cls);
    wire   hit1     = blk_hit(mask_ff[1], cfg_ff[1], acc_req.addr, cls);
    wire   any_hit  = hit0 || hit1;
    wire   sel_blk  = !hit0;
    wire   wr_lock  = any_hit && acc_req.write &&
                      mask_ff[sel_blk][WLOCK_BIT];
    wire   go_dram  = take && any_hit && !wr_lock;
    wire   to_cs    = take && !go_dram;
    wire   same_row = open_ff && (open_blk_ff == sel_blk) &&
                      (open_row_ff == acc_req.addr[31:ROW_LSB]);
    wire   cur_pm   = cfg_ff[blk_ff][PAGE_BIT];

    assign acc_ready = (state_ff == S_IDLE);

    // access sequencer
    always_comb begin
        nxt_state    = state_ff;
        nxt_cur      = cur_ff;
        nxt_blk      = blk_ff;
        nxt_pend     = pend_ff;
        nxt_open     = open_ff;
        nxt_open_blk = open_blk_ff;
        nxt_open_row = open_row_ff;
        case (state_ff)
            S_IDLE: begin
                if (go_dram) begin
                    nxt_cur = acc_req;
                    nxt_blk = sel_blk;
                    if (same_row) begin
                        nxt_state = S_RDWR;
                    end else if (open_ff) begin
                        nxt_state = S_PRE;
                        nxt_pend  = 1'b1;
                    end else begin
                        nxt_state = S_ACT;
                    end
                end
            end
            S_ACT: begin
                nxt_state    = S_RDWR;
                nxt_open     = 1'b1;
                nxt_open_blk = blk_ff;
                nxt_open_row = cur_ff.addr[31:ROW_LSB];
            end
            S_RDWR: begin
                if (cur_pm) begin
                    nxt_state = S_IDLE;
                end else begin
                    nxt_state = S_PRE;
                    nxt_pend  = 1'b0;
                end
            end
            S_PRE: begin
                nxt_open  = 1'b0;
                nxt_pend  = 1'b0;
                nxt_state = pend_ff ? S_ACT : S_IDLE;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // pin image for the next cycle
    wire [1:0] nxt_pw   = cfg_ff[nxt_blk][PW_MSB:PW_LSB];
    wire       nxt_xcol = cfg_ff[nxt_blk][XCOL_BIT];
    always_comb begin
        nxt_sdram = PINS_IDLE;
        case (nxt_state)
            S_ACT: begin
                nxt_sdram.cs_n[nxt_blk] = 1'b0;
                nxt_sdram.ras_n         = 1'b0;
                nxt_sdram.addr = mux_addr(nxt_cur.addr, nxt_pw, nxt_xcol,
                                          1'b0);
            end
            S_RDWR: begin
                nxt_sdram.cs_n[nxt_blk] = 1'b0;
                nxt_sdram.cas_n         = 1'b0;
                nxt_sdram.we_n          = !nxt_cur.write;
                nxt_sdram.addr = mux_addr(nxt_cur.addr, nxt_pw, nxt_xcol,
                                          1'b1);
            end
            S_PRE: begin
                nxt_sdram.cs_n[open_blk_ff] = 1'b0;
                nxt_sdram.ras_n             = 1'b0;
                nxt_sdram.we_n              = 1'b0;
            end
            default: begin
                nxt_sdram = PINS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff    <= S_IDLE;
            cur_ff      <= '0;
            blk_ff      <= 1'b0;
            pend_ff     <= 1'b0;
            open_ff     <= 1'b0;
            open_blk_ff <= 1'b0;
            open_row_ff <= 23'h0;
            sdram_ff    <= PINS_IDLE;
        end else begin
            state_ff    <= nxt_state;
            cur_ff      <= nxt_cur;
            blk_ff      <= nxt_blk;
            pend_ff     <= nxt_pend;
            open_ff     <= nxt_open;
            open_blk_ff <= nxt_open_blk;
            open_row_ff <= nxt_open_row;
            sdram_ff    <= nxt_sdram;
        end
    end

    // one-cycle result pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'b0;
            hit0_ff <= 1'b0;
            hit1_ff <= 1'b0;
            wl_ff   <= 1'b0;
            csp_ff  <= 1'b0;
        end else begin
            done_ff <= to_cs || (state_ff == S_RDWR);
            hit0_ff <= take && hit0;
            hit1_ff <= take && !hit0 && hit1;
            wl_ff   <= take && wr_lock;
            csp_ff  <= to_cs;
        end
    end

    assign sdram     = sdram_ff;
    assign acc_done  = done_ff;
    assign acc_hit   = {hit1_ff, hit0_ff};
    assign wlock_err = wl_ff;
    assign cs_pass   = csp_ff;

    // apb register access
    wire       wr_en   = psel && penable && pwrite;
    wire       setup   = psel && !penable;
    wire       hit_m0  = (paddr == OFS_MASK0);
    wire       hit_m1  = (paddr == OFS_MASK1);
    wire       hit_c0  = (paddr == OFS_CFG0);
    wire       hit_c1  = (paddr == OFS_CFG1);
    wire       hit_st  = (paddr == OFS_STATUS);
    wire       hit_im  = (paddr == OFS_IRQMASK);
    wire       hit_sr  = (paddr == OFS_STATE);
    wire       mapped  = hit_m0 || hit_m1 || hit_c0 || hit_c1 ||
                         hit_st || hit_im || hit_sr;
    wire [31:0] state_word = {open_row_ff, 6'h00, open_blk_ff, open_ff,
                              (state_ff != S_IDLE)};
    wire [31:0] rd_word =
        hit_m0 ? mask_ff[0] :
        hit_m1 ? mask_ff[1] :
        hit_c0 ? cfg_ff[0]  :
        hit_c1 ? cfg_ff[1]  :
        hit_st ? {29'h0, status_ff}  :
        hit_im ? {29'h0, irqmask_ff} :
        hit_sr ? state_word : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_ff;

    // sticky events, set wins over write-one clear
    wire            wl0_ev = take && wr_lock && !sel_blk;
    wire            wl1_ev = take && wr_lock && sel_blk;
    wire            csp_ev = take && !any_hit;
    wire [ST_W-1:0] ev  = {csp_ev, wl1_ev, wl0_ev};
    wire [ST_W-1:0] clr = (wr_en && hit_st) ? pwdata[ST_W-1:0] : '0;
    assign nxt_status = (status_ff & ~clr) | ev;
    assign irq        = |(status_ff & irqmask_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff[0] <= MASK_RESET;
            mask_ff[1] <= MASK_RESET;
            cfg_ff[0]  <= CFG_RESET;
            cfg_ff[1]  <= CFG_RESET;
            status_ff  <= STATUS_RESET;
            irqmask_ff <= STATUS_RESET;
            prdata_ff  <= 32'h0;
        end else begin
            if (wr_en && hit_m0) mask_ff[0] <= pwdata & MASK_WMASK;
            if (wr_en && hit_m1) mask_ff[1] <= pwdata & MASK_WMASK;
            if (wr_en && hit_c0) cfg_ff[0]  <= pwdata & CFG_WMASK;
            if (wr_en && hit_c1) cfg_ff[1]  <= pwdata & CFG_WMASK;
            if (wr_en && hit_im) irqmask_ff <= pwdata[ST_W-1:0];
            status_ff <= nxt_status;
            if (setup) prdata_ff <= rd_word;
        end
    end

    // checks
    no_hit_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
        take && !mask_ff[0][ENABLE_BIT] && !mask_ff[1][ENABLE_BIT]
        |=> !acc_hit[0] && !acc_hit[1] && cs_pass)
        else $error("hit while decode disabled");
    lock_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
        take && wr_lock |=> wlock_err && cs_pass && acc_done &&
        sdram.cs_n == 2'b11)
        else $error("locked write reached dram");
    lock_to_cs_a: assert property (@(posedge pclk) disable iff (!presetn)
        wlock_err |-> cs_pass)
        else $error("locked write not passed to chip select");
    class_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        take && (mask_ff[0][ATM_MSB:ATM_LSB] & cls) != 6'h00
        |=> !acc_hit[0])
        else $error("masked class hit block 0");
    alt_class_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_valid && acc_req.alt_master |-> cls == 6'h10)
        else $error("alternate master misclassified");
    base_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
        take && mask_ff[0][ENABLE_BIT] &&
        (((acc_req.addr ^ cfg_ff[0]) & ~mask_ff[0] & BASE_FIELD) != 0)
        |=> !acc_hit[0])
        else $error("base mismatch still hit");
    row_col_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sdram.ras_n && sdram.we_n |=> !sdram.cas_n &&
        sdram.addr[31:20] == 12'h0)
        else $error("row phase not followed by column phase");
    burst_close_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == S_RDWR && !cur_pm |=> !sdram.ras_n && !sdram.we_n
        ##1 !open_ff)
        else $error("burst-only page left open");
    col8_a: assert property (@(posedge pclk) disable iff (!presetn)
        nxt_state == S_RDWR && nxt_pw == PW_8
        |=> sdram.addr[17] == $past(nxt_cur.addr[0]) &&
            sdram.addr[9] == $past(nxt_cur.addr[8]))
        else $error("8-bit column mapping wrong");
    col10_a: assert property (@(posedge pclk) disable iff (!presetn)
        nxt_state == S_RDWR && nxt_pw == PW_8 && nxt_xcol
        |=> sdram.addr[19] == $past(nxt_cur.addr[18]))
        else $error("ten-column bit 18 missing");

endmodule : sdram_block_decode

// ===== test/sdram_model.sv
// sdram device model: records row and column addresses, flags bad order
`timescale 1ns/10ps
module sdram_model (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire sdram_decode_pkg::sdram_pins_t sdram,
    output logic [31:0]                      row_ff,
    output logic [31:0]                      col_ff,
    output logic [7:0]                       act_ff,
    output logic [7:0]                       cas_ff,
    output logic                             err_ff
);
    import sdram_decode_pkg::*;
    logic open_ff;
    wire logic sel = (sdram.cs_n != 2'b11);
    wire logic act = sel & !sdram.ras_n & sdram.cas_n & sdram.we_n;
    wire logic col = sel & sdram.ras_n & !sdram.cas_n;
    wire logic pre = sel & !sdram.ras_n & sdram.cas_n & !sdram.we_n;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {row_ff, col_ff, act_ff, cas_ff, err_ff, open_ff} <= '0;
        end else begin
            if (act) begin
                row_ff  <= sdram.addr;
                act_ff  <= act_ff + 8'h01;
                open_ff <= 1'b1;
                err_ff  <= err_ff | open_ff;
            end
            if (pre)
                open_ff <= 1'b0;
            if (col) begin
                col_ff <= sdram.addr;
                cas_ff <= cas_ff + 8'h01;
                err_ff <= err_ff | !open_ff;
            end
        end
    end
endmodule : sdram_model

// ===== test/test_sdram_block_decode.sv
// self-checking bench for the sdram block decoder
`timescale 1ns/10ps
module test_sdram_block_decode;
    import sdram_decode_pkg::*;
    localparam logic [31:0] BASE = 32'h00040000;
    localparam logic [31:0] ADDR = 32'h00075a35;
    logic pclk, presetn, psel, penable, pwrite, acc_valid, slverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, row, col;
    logic pready, pslverr, acc_ready, acc_done, wlock_err, cs_pass, irq;
    logic [1:0] acc_hit, hit;
    logic wl, csp, merr;
    logic [7:0] n_act, n_cas, a0, c0;
    acc_req_t acc_req;
    sdram_pins_t sdram;
    int mismatches, n_checks;
    sdram_block_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .acc_valid(acc_valid), .acc_req(acc_req), .acc_ready(acc_ready),
        .acc_done(acc_done), .acc_hit(acc_hit), .wlock_err(wlock_err),
        .cs_pass(cs_pass), .sdram(sdram), .irq(irq));
    sdram_model mdl (.pclk(pclk), .presetn(presetn), .sdram(sdram),
        .row_ff(row), .col_ff(col), .act_ff(n_act), .cas_ff(n_cas),
        .err_ff(merr));
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;
    task automatic chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic        w,
                       input logic [7:0]  a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat    = prdata;
        slverr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic access(input acc_req_t r);
        bit seen;
        seen = 0; hit = 2'b00; wl = 0; csp = 0;
        acc_valid <= 1'b1;
        acc_req   <= r;
        do begin
            @(posedge pclk);
        end while (acc_ready !== 1'b1);
        acc_valid <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            @(posedge pclk);
            hit = hit | acc_hit; wl = wl | wlock_err; csp = csp | cs_pass;
            if (acc_done === 1'b1) seen = 1;
            if (seen && acc_ready === 1'b1) break;
        end
        chk("done seen", 1, 32'(seen));
    endtask : access
    function automatic acc_req_t mk(logic [31:0] a, logic w, int c);
        acc_req_t r;
        r = '0; r.addr = a; r.write = w;
        r.cpu_space = (c == CLS_CPU); r.alt_master = (c == CLS_ALT);
        r.supervisor = (c == CLS_SC) || (c == CLS_SD);
        r.code = (c == CLS_SC) || (c == CLS_UC);
        return r;
    endfunction : mk
    function automatic logic [31:0] colmux(logic [31:0] a, int lo, int xp,
                                           int xb, logic xc);
        logic [31:0] c;
        c = '0;
        for (int i = lo; i <= 8; i++) c[17-i] = a[i];
        if (xc) c[xp] = a[xb];
        return c;
    endfunction : colmux
    task automatic t_reset;
        apb(0, OFS_MASK0, 0); chk("mask0", MASK_RESET, rdat);
        apb(0, OFS_CFG0, 0); chk("cfg0", CFG_RESET, rdat);
        apb(1, OFS_MASK1, '1); apb(0, OFS_MASK1, 0);
        chk("mask1", MASK_WMASK, rdat);
        apb(1, OFS_MASK1, 0); apb(1, OFS_CFG0, BASE | 32'h10);
        access(mk(ADDR, 0, CLS_UD)); chk("hit off", 0, 32'(hit));
        chk("pass off", 1, 32'(csp));
    endtask : t_reset
    task automatic t_widths;
        logic [1:0] pw[3] = '{2'b01, 2'b10, 2'b00};
        apb(1, OFS_MASK0, 1);
        for (int w = 0; w < 6; w++) begin
            apb(1, OFS_CFG0, BASE | (32'(pw[w%3]) << 4) | (32'(w / 3) << 1));
            access(mk(ADDR, 0, CLS_UD)); chk("hit", 1, 32'(hit));
            chk("row", ADDR >> 9, row >> 9);
            chk("col", colmux(ADDR, w%3, 19-w%3, 18-w%3, w/3),
                col);
        end
    endtask : t_widths
    task automatic t_classes;
        for (int c = 0; c < 6; c++) begin
            apb(1, OFS_MASK0, 1 | (32'h1 << (ATM_LSB + c)));
            access(mk(ADDR, 0, c));
            chk("masked", 0, 32'(hit));
            apb(1, OFS_MASK0, 1);
            access(mk(ADDR, 0, c));
            chk("unmasked", 1, 32'(hit));
        end
    endtask : t_classes
    task automatic t_exclude;
        apb(1, OFS_MASK0, 32'h02100001);
        access(mk(ADDR ^ 32'h02100000, 0, CLS_SD));
        chk("excl", 1, 32'(hit));
        apb(1, OFS_MASK0, 32'h00100001);
        access(mk(ADDR ^ 32'h02100000, 0, CLS_SD));
        chk("cmp", 0, 32'(hit));
    endtask : t_exclude
    task automatic t_lock;
        apb(1, OFS_STATUS, 32'h7); apb(1, OFS_IRQMASK, 1);
        apb(1, OFS_MASK0, 32'h101);
        access(mk(ADDR, 0, CLS_UD)); chk("lock rd", 1, 32'(hit));
        access(mk(ADDR, 1, CLS_UD)); chk("lock err", 1, 32'(wl));
        chk("lock pass", 1, 32'(csp));
        apb(0, OFS_STATUS, 0); chk("status", 1, rdat & 32'h7);
        chk("irq on", 1, 32'(irq));
        apb(1, OFS_STATUS, 1); apb(0, OFS_STATUS, 0);
        chk("cleared", 0, rdat & 32'h7);
        chk("irq off", 0, 32'(irq));
        apb(0, 8'h1c, 0); chk("slverr", 1, 32'(slverr));
        chk("unmapped", 0, rdat);
    endtask : t_lock
    task automatic t_page(input logic cont, input logic [7:0] acts);
        apb(1, OFS_MASK0, 1);
        apb(1, OFS_CFG0, BASE | 32'h10 | (32'(cont) << 2));
        a0 = n_act; c0 = n_cas;
        access(mk(ADDR, 0, CLS_UD)); access(mk(ADDR + 4, 0, CLS_UD));
        chk("activates", 32'(acts), 32'(n_act - a0));
        chk("columns", 2, 32'(n_cas - c0));
        chk("order", 0, 32'(merr));
    endtask : t_page
    task automatic t_block1;
        apb(1, OFS_STATUS, 32'h7);
        apb(1, OFS_MASK0, 0);
        apb(1, OFS_CFG1, BASE | 32'h10);
        apb(1, OFS_MASK1, 32'h101);
        access(mk(ADDR, 0, CLS_UD));
        chk("hit blk1", 2, 32'(hit));
        chk("order blk1", 0, 32'(merr));
        a0 = n_act;
        access(mk(ADDR, 1, CLS_UD));
        chk("lock blk1", 1, 32'(wl));
        chk("lock no act", 0, 32'(n_act - a0));
        apb(0, OFS_STATUS, 0);
        chk("status blk1", 2, rdat & 32'h7);
        apb(1, OFS_MASK1, 0);
        access(mk(ADDR, 0, CLS_UD));
        chk("miss pass", 1, 32'(csp));
        apb(0, OFS_STATUS, 0);
        chk("status miss", 6, rdat & 32'h7);
        chk("irq masked", 0, 32'(irq));
        apb(1, OFS_STATUS, 32'h7);
    endtask : t_block1
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        conclude();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, acc_valid} = '0;
        acc_req = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_widths();
        t_classes();
        t_exclude();
        t_lock();
        t_page(1'b0, 8'd2);
        t_page(1'b1, 8'd1);
        t_block1();
        conclude();
    end
endmodule : test_sdram_block_decode
